/* design/acsi_params.svh */
// Address map, field positions and reset values of the accelerator socket
`ifndef ACSI_PARAMS_SVH
`define ACSI_PARAMS_SVH
`define ACSI_SLOTS 32
`define ACSI_ADDR_W 16
`define ACSI_DATA_W 32
`define ACSI_EXT_W 19
`define ACSI_REGION_HI 15
`define ACSI_REGION_LO 14
`define ACSI_SLOT_HI 13
`define ACSI_SLOT_LO 9
`define ACSI_OFS_HI 8
`define ACSI_WIN_WORDS 512
`define ACSI_REG_WORDS 16
`define ACSI_REGION_REG_RD 2'h0
`define ACSI_REGION_REG_WR 2'h1
`define ACSI_REGION_RAM_RD 2'h2
`define ACSI_REGION_RAM_WR 2'h3
`define ACSI_MASTER_SLOT 5'h00
`define ACSI_PRESENCE_OFS 9'h000
`define ACSI_CTRL_OFS 4'h0
`define ACSI_STATUS_OFS 4'h0
`define ACSI_ZERO_WORD 32'h0000_0000
`endif

/* design/acsi_pkg.sv */
// Types used by the framework end of the accelerator socket
package acsi_pkg;
   typedef enum logic [3:0] {
      ACSI_IDLE = 4'h1,
      ACSI_WRITE = 4'h2,
      ACSI_FLUSH = 4'h4,
      ACSI_READ = 4'h8
   } acsi_state_t;
endpackage

/* design/acsi_if.sv */
// Socket signals between the framework and all accelerator slots
`timescale 1ns/1ps
`include "acsi_params.svh"
interface acsi_if;
   logic clk;
   logic rst;
   logic [`ACSI_SLOTS-1:0] strobe_reg_read;
   logic [`ACSI_SLOTS-1:0] strobe_reg_write;
   logic [`ACSI_SLOTS-1:0] strobe_ram_read;
   logic [`ACSI_SLOTS-1:0] strobe_ram_write;
   logic [`ACSI_ADDR_W-1:0] write_addr;
   logic [`ACSI_DATA_W-1:0] data_in;
   logic write_valid;
   logic [`ACSI_SLOTS-1:0] write_rdy;
   logic [`ACSI_ADDR_W-1:0] read_addr;
   logic [`ACSI_DATA_W-1:0] data_out [`ACSI_SLOTS];
   logic [`ACSI_SLOTS-1:0] strobe_out;
   logic [`ACSI_SLOTS-1:0] present;
   logic mm_rdq_empty;
   logic mm_wrq_full;
   logic [`ACSI_DATA_W-1:0] mm_rdq_word;
   logic [`ACSI_SLOTS-1:0] mm_job_accepted;
   logic [`ACSI_SLOTS-1:0] mm_wrq_granted;
   logic [`ACSI_SLOTS-1:0] mm_rdq_granted;
   logic [`ACSI_SLOTS-1:0] mm_job_request;
   logic [`ACSI_SLOTS-1:0] mm_job_is_read;
   logic [`ACSI_SLOTS-1:0] mm_rdq_take;
   logic [`ACSI_SLOTS-1:0] mm_wrq_put;
   logic [`ACSI_EXT_W-1:0] mm_ext_location [`ACSI_SLOTS];
   logic [`ACSI_DATA_W-1:0] mm_wrq_word [`ACSI_SLOTS];
   modport framework (
      output clk, rst, strobe_reg_read, strobe_reg_write, strobe_ram_read,
      output strobe_ram_write, write_addr, data_in, write_valid, read_addr,
      output mm_rdq_empty, mm_wrq_full, mm_rdq_word, mm_job_accepted,
      output mm_wrq_granted, mm_rdq_granted,
      input write_rdy, data_out, strobe_out, present, mm_job_request,
      input mm_job_is_read, mm_rdq_take, mm_wrq_put, mm_ext_location, mm_wrq_word
   );
   modport slot (
      input clk, rst, strobe_reg_read, strobe_reg_write, strobe_ram_read,
      input strobe_ram_write, write_addr, data_in, write_valid, read_addr,
      input mm_rdq_empty, mm_wrq_full, mm_rdq_word, mm_job_accepted,
      input mm_wrq_granted, mm_rdq_granted,
      output write_rdy, data_out, strobe_out, present, mm_job_request,
      output mm_job_is_read, mm_rdq_take, mm_wrq_put, mm_ext_location, mm_wrq_word
   );
endinterface

/* design/acsi_slot.sv */
// One accelerator slot: region decode, local RAM and memory-manager client
`timescale 1ns/1ps
`include "acsi_params.svh"
module acsi_slot #(
   parameter int SLOT_INDEX = 1
) (
   acsi_if.slot sock,
   output logic [`ACSI_DATA_W-1:0] user_ctrl,
   input wire logic [`ACSI_DATA_W-1:0] user_status,
   input wire logic [`ACSI_OFS_HI:0] user_ram_addr,
   input wire logic [`ACSI_DATA_W-1:0] user_ram_wdata,
   input wire logic user_ram_we,
   output logic [`ACSI_DATA_W-1:0] user_ram_rdata,
   input wire logic user_job_req,
   input wire logic user_job_is_read,
   input wire logic [`ACSI_EXT_W-1:0] user_job_loc,
   output logic user_job_done,
   input wire logic user_put,
   input wire logic [`ACSI_DATA_W-1:0] user_put_word,
   output logic user_put_ready,
   input wire logic user_take,
   output logic user_take_ready,
   output logic [`ACSI_DATA_W-1:0] user_take_word,
   output logic user_take_valid
);
   localparam logic [4:0] IDX = 5'(SLOT_INDEX);
   logic [`ACSI_DATA_W-1:0] ram [`ACSI_WIN_WORDS];
   logic [`ACSI_DATA_W-1:0] wreg [`ACSI_REG_WORDS];
   logic [`ACSI_OFS_HI:0] wofs;
   logic [`ACSI_OFS_HI:0] rofs;
   logic rd_sel;
   logic rd_done;
   logic job_pending;
   logic [`ACSI_DATA_W-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   assign wofs = sock.write_addr[`ACSI_OFS_HI:0];
   assign rofs = sock.read_addr[`ACSI_OFS_HI:0];
   assign rd_sel = sock.strobe_reg_read[IDX] | sock.strobe_ram_read[IDX];
   assign sock.present[IDX] = 1'b1;
   // Local RAM takes a word every cycle, so the slot is always ready
   assign sock.write_rdy[IDX] = 1'b1;
   assign user_ctrl = wreg[`ACSI_CTRL_OFS];

   always_ff @(posedge sock.clk) begin
      if (sock.rst) begin
         for (int i = 0; i < `ACSI_REG_WORDS; i++) begin
            wreg[i] <= `ACSI_ZERO_WORD;
         end
      end else if (sock.write_valid && sock.strobe_reg_write[IDX]) begin
         wreg[wofs[3:0]] <= sock.data_in;
      end
   end

   // Bus write wins over a user write in the same cycle
   always_ff @(posedge sock.clk) begin
      if (sock.write_valid && sock.strobe_ram_write[IDX]) begin
         ram[wofs] <= sock.data_in;
      end else if (user_ram_we) begin
         ram[user_ram_addr] <= user_ram_wdata;
      end
      user_ram_rdata <= ram[user_ram_addr];
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      if (sock.strobe_ram_read[IDX]) begin
         rd_word = ram[rofs];
      end else if (rofs[3:0] == `ACSI_STATUS_OFS) begin
         rd_word = user_status;
      end else begin
         rd_word = wreg[rofs[3:0]];
      end
   end

   // One answer pulse per read strobe assertion
   always_ff @(posedge sock.clk) begin
      if (sock.rst) begin
         sock.strobe_out[IDX] <= 1'b0;
         rd_done <= 1'b0;
         sock.data_out[IDX] <= `ACSI_ZERO_WORD;
      end else begin
         sock.strobe_out[IDX] <= rd_sel && !rd_done;
         rd_done <= rd_sel;
         if (rd_sel && !rd_done) begin
            sock.data_out[IDX] <= rd_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sock.clk) begin
      if (sock.rst) begin
         job_pending <= 1'b0;
         sock.mm_job_is_read[IDX] <= 1'b0;
         sock.mm_ext_location[IDX] <= 19'h0_0000;
         user_job_done <= 1'b0;
      end else begin
         user_job_done <= job_pending && sock.mm_job_accepted[IDX];
         if (job_pending && sock.mm_job_accepted[IDX]) begin
            job_pending <= 1'b0;
         end else if (!job_pending && user_job_req) begin
            job_pending <= 1'b1;
            sock.mm_job_is_read[IDX] <= user_job_is_read;
            sock.mm_ext_location[IDX] <= user_job_loc;
         end
      end
   end
   assign sock.mm_job_request[IDX] = job_pending;

   assign user_put_ready = sock.mm_wrq_granted[IDX] && !sock.mm_wrq_full;
   assign user_take_ready = sock.mm_rdq_granted[IDX] && !sock.mm_rdq_empty;
   assign sock.mm_wrq_put[IDX] = user_put && user_put_ready;
   assign sock.mm_wrq_word[IDX] = user_put_word;
   assign sock.mm_rdq_take[IDX] = user_take && user_take_ready;

   always_ff @(posedge sock.clk) begin
      if (sock.rst) begin
         user_take_valid <= 1'b0;
         user_take_word <= `ACSI_ZERO_WORD;
      end else begin
         user_take_valid <= sock.mm_rdq_take[IDX];
         if (sock.mm_rdq_take[IDX]) begin
            user_take_word <= sock.mm_rdq_word;
         end
      end
   end
endmodule

/* design/acsi_framework.sv */
// Framework end: address decode, region strobes, write flow and queue arbiter
// What this block does
// - Up to 31 slots, one presence bit each
// - Absent or unassigned slots read presence zero
// - Four strobes per slot: region and direction
// - Slot decodes only nine low address bits
// - Register windows at 0000 and 4000, 0x200 each
// - RAM windows at 8000 and C000, 0x200 each
// - Each slot owns four equal sections
// - Exactly one strobe of target slot asserted
// - Slots keep data in RAM, flags in registers
// - Slot may handle registers and RAM alike
// - One rising clock, active-high global reset
// - Strobes are one-bit active-high slot inputs
// - Writes carry address, word and valid flag
// - Slot returns read word with present flag
// - Slot consumes word only while valid high
// - New words only while slot signals ready
// - One write may carry several words
// - Pop takes one word; empty flag from manager
// - Push places one word; full flag from manager
// - Separate grants for write and read queues
// - Slot gives 19-bit external location per job
`timescale 1ns/1ps
`include "acsi_params.svh"
module acsi_framework (
   input wire logic clk,
   input wire logic rst,
   acsi_if.framework sock,
   input wire logic host_wr_start,
   input wire logic [`ACSI_ADDR_W-1:0] host_addr,
   input wire logic host_wr_valid,
   input wire logic [`ACSI_DATA_W-1:0] host_wr_data,
   input wire logic host_wr_last,
   output logic host_wr_ready,
   input wire logic host_rd_start,
   output logic [`ACSI_DATA_W-1:0] host_rd_data,
   output logic host_rd_valid,
   output logic host_idle,
   output logic [`ACSI_DATA_W-1:0] slot_presence_word,
   input wire logic ext_rdq_empty,
   input wire logic ext_wrq_full,
   input wire logic ext_job_accepted,
   input wire logic [`ACSI_DATA_W-1:0] ext_rdq_word,
   output logic ext_job_request,
   output logic ext_job_is_read,
   output logic [`ACSI_EXT_W-1:0] ext_location,
   output logic ext_rdq_take,
   output logic ext_wrq_put,
   output logic [`ACSI_DATA_W-1:0] ext_wrq_word
);
   acsi_pkg::acsi_state_t state;
   logic [1:0] region;
   logic [4:0] slot;
   logic [`ACSI_ADDR_W-1:0] addr;
   logic [`ACSI_SLOTS-1:0] sel;
   logic [4:0] owner;
   logic [4:0] next_owner;
   logic next_found;
   logic slot_live;
   logic slot_rdy;

   ////////////////////////////////////////////////////////////////////////////
   assign sock.clk = clk;
   assign sock.rst = rst;

   // Bit 0 is the master window and never a slot
   always_ff @(posedge clk) begin
      if (rst) begin
         slot_presence_word <= `ACSI_ZERO_WORD;
      end else begin
         slot_presence_word <= {sock.present[`ACSI_SLOTS-1:1], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Top two bits pick the section, next five the slot window
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= acsi_pkg::ACSI_IDLE;
         region <= `ACSI_REGION_REG_RD;
         slot <= `ACSI_MASTER_SLOT;
         addr <= 16'h0000;
      end else begin
         unique case (state)
            acsi_pkg::ACSI_IDLE: begin
               if (host_wr_start || host_rd_start) begin
                  region <= host_addr[`ACSI_REGION_HI:`ACSI_REGION_LO];
                  slot <= host_addr[`ACSI_SLOT_HI:`ACSI_SLOT_LO];
                  addr <= host_addr;
                  state <= host_wr_start ? acsi_pkg::ACSI_WRITE : acsi_pkg::ACSI_READ;
               end
            end
            acsi_pkg::ACSI_WRITE: begin
               if (host_wr_valid && host_wr_ready) begin
                  addr <= addr + 16'h0001;
                  if (host_wr_last) begin
                     state <= acsi_pkg::ACSI_FLUSH;
                  end
               end
            end
            acsi_pkg::ACSI_FLUSH: begin
               state <= acsi_pkg::ACSI_IDLE;
            end
            acsi_pkg::ACSI_READ: begin
               if (!slot_live || sock.strobe_out[slot]) begin
                  state <= acsi_pkg::ACSI_IDLE;
               end
            end
            default: begin
               state <= acsi_pkg::ACSI_IDLE;
            end
         endcase
      end
   end
   assign host_idle = state == acsi_pkg::ACSI_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // Master window and empty slots get no strobe
   assign slot_live = slot != `ACSI_MASTER_SLOT && sock.present[slot];
   assign sel = slot_live && !host_idle ? `ACSI_SLOTS'(1) << slot : '0;
   assign sock.strobe_reg_read = region == `ACSI_REGION_REG_RD ? sel : '0;
   assign sock.strobe_reg_write = region == `ACSI_REGION_REG_WR ? sel : '0;
   assign sock.strobe_ram_read = region == `ACSI_REGION_RAM_RD ? sel : '0;
   assign sock.strobe_ram_write = region == `ACSI_REGION_RAM_WR ? sel : '0;
   assign sock.read_addr = addr;

   // Words to the master or an empty slot are taken and dropped
   assign slot_rdy = !slot_live || sock.write_rdy[slot];
   assign host_wr_ready = state == acsi_pkg::ACSI_WRITE && slot_rdy;

   always_ff @(posedge clk) begin
      if (rst) begin
         sock.write_valid <= 1'b0;
         sock.data_in <= `ACSI_ZERO_WORD;
         sock.write_addr <= 16'h0000;
      end else begin
         sock.write_valid <= host_wr_valid && host_wr_ready && slot_live;
         if (host_wr_valid && host_wr_ready) begin
            sock.data_in <= host_wr_data;
            sock.write_addr <= addr;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         host_rd_valid <= 1'b0;
         host_rd_data <= `ACSI_ZERO_WORD;
      end else begin
         host_rd_valid <= 1'b0;
         if (state == acsi_pkg::ACSI_READ) begin
            if (slot_live && sock.strobe_out[slot]) begin
               host_rd_valid <= 1'b1;
               host_rd_data <= sock.data_out[slot];
            end else if (!slot_live) begin
               host_rd_valid <= 1'b1;
               host_rd_data <= (slot == `ACSI_MASTER_SLOT && region == `ACSI_REGION_REG_RD
                  && addr[`ACSI_OFS_HI:0] == `ACSI_PRESENCE_OFS) ?
                  slot_presence_word : `ACSI_ZERO_WORD;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Owner keeps the queues until it has no job pending and another slot asks
   always_comb begin
      next_owner = owner;
      next_found = 1'b0;
      for (int i = 1; i < `ACSI_SLOTS; i++) begin
         if (!next_found && sock.mm_job_request[i] && sock.present[i]) begin
            next_owner = 5'(i);
            next_found = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         owner <= `ACSI_MASTER_SLOT;
      end else if (owner == `ACSI_MASTER_SLOT || !sock.mm_job_request[owner]) begin
         if (next_found) begin
            owner <= next_owner;
         end
      end
   end

   always_comb begin
      sock.mm_wrq_granted = '0;
      sock.mm_rdq_granted = '0;
      sock.mm_job_accepted = '0;
      if (owner != `ACSI_MASTER_SLOT) begin
         sock.mm_wrq_granted[owner] = 1'b1;
         sock.mm_rdq_granted[owner] = 1'b1;
         sock.mm_job_accepted[owner] = ext_job_accepted;
      end
   end

   assign sock.mm_rdq_empty = ext_rdq_empty;
   assign sock.mm_wrq_full = ext_wrq_full;
   assign sock.mm_rdq_word = ext_rdq_word;
   assign ext_job_request = owner != `ACSI_MASTER_SLOT && sock.mm_job_request[owner];
   assign ext_job_is_read = sock.mm_job_is_read[owner];
   assign ext_location = sock.mm_ext_location[owner];
   assign ext_rdq_take = owner != `ACSI_MASTER_SLOT && sock.mm_rdq_take[owner] && !ext_rdq_empty;
   assign ext_wrq_put = owner != `ACSI_MASTER_SLOT && sock.mm_wrq_put[owner] && !ext_wrq_full;
   assign ext_wrq_word = sock.mm_wrq_word[owner];
endmodule

/* testbench/acsi_assertions.sv */
// Checker on the socket signals between the framework and the slots
`timescale 1ns/1ps
`include "acsi_params.svh"
module acsi_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`ACSI_SLOTS-1:0] strobe_reg_read,
   input wire logic [`ACSI_SLOTS-1:0] strobe_reg_write,
   input wire logic [`ACSI_SLOTS-1:0] strobe_ram_read,
   input wire logic [`ACSI_SLOTS-1:0] strobe_ram_write,
   input wire logic [`ACSI_ADDR_W-1:0] write_addr,
   input wire logic write_valid,
   input wire logic [`ACSI_SLOTS-1:0] write_rdy,
   input wire logic [`ACSI_ADDR_W-1:0] read_addr,
   input wire logic [`ACSI_SLOTS-1:0] strobe_out,
   input wire logic mm_rdq_empty,
   input wire logic mm_wrq_full,
   input wire logic [`ACSI_SLOTS-1:0] mm_job_accepted,
   input wire logic [`ACSI_SLOTS-1:0] mm_wrq_granted,
   input wire logic [`ACSI_SLOTS-1:0] mm_rdq_granted,
   input wire logic [`ACSI_SLOTS-1:0] mm_job_request,
   input wire logic [`ACSI_SLOTS-1:0] mm_rdq_take,
   input wire logic [`ACSI_SLOTS-1:0] mm_wrq_put
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_strobe_one_hot: assert property (
      $onehot0({strobe_reg_read, strobe_reg_write, strobe_ram_read, strobe_ram_write}))
      else $error("more than one region strobe high");
   a_master_no_strobe: assert property (
      !(strobe_reg_read[0] | strobe_reg_write[0] | strobe_ram_read[0] | strobe_ram_write[0]))
      else $error("strobe given to master index");
   a_reg_wr_decode: assert property (
      write_valid && |strobe_reg_write |-> write_addr[15:14] == `ACSI_REGION_REG_WR
      && strobe_reg_write[write_addr[13:9]]) else $error("register write strobe misdecoded");
   a_ram_wr_decode: assert property (
      write_valid && |strobe_ram_write |-> write_addr[15:14] == `ACSI_REGION_RAM_WR
      && strobe_ram_write[write_addr[13:9]]) else $error("ram write strobe misdecoded");
   a_reg_rd_decode: assert property (
      |strobe_reg_read |-> read_addr[15:14] == `ACSI_REGION_REG_RD
      && strobe_reg_read[read_addr[13:9]]) else $error("register read strobe misdecoded");
   a_ram_rd_decode: assert property (
      |strobe_ram_read |-> read_addr[15:14] == `ACSI_REGION_RAM_RD
      && strobe_ram_read[read_addr[13:9]]) else $error("ram read strobe misdecoded");
   a_valid_in_write: assert property (
      write_valid |-> |((strobe_reg_write | strobe_ram_write) & write_rdy))
      else $error("write word outside a ready write");
   a_burst_addr_step: assert property (
      write_valid && $past(write_valid) |-> write_addr == $past(write_addr) + 16'h0001)
      else $error("burst address did not step by one");
   a_out_one_cycle: assert property (
      |strobe_out |=> strobe_out == 32'h0000_0000) else $error("read present longer than a cycle");
   a_out_on_read: assert property (
      |strobe_out |-> (strobe_out & ~$past(strobe_reg_read | strobe_ram_read)) == 32'h0000_0000)
      else $error("read present without read strobe");
   a_job_held: assert property (
      |(mm_job_request & ~mm_job_accepted) |=>
      ($past(mm_job_request & ~mm_job_accepted) & ~mm_job_request) == 32'h0000_0000)
      else $error("job request dropped before acceptance");
   a_grants_paired: assert property (
      $onehot0(mm_wrq_granted) && mm_rdq_granted == mm_wrq_granted)
      else $error("queue grants not paired to one owner");
   a_put_gated: assert property (
      |mm_wrq_put |-> !mm_wrq_full && $onehot(mm_wrq_put)
      && (mm_wrq_put & ~mm_wrq_granted) == 32'h0000_0000) else $error("put while full or ungranted");
   a_take_gated: assert property (
      |mm_rdq_take |-> !mm_rdq_empty && $onehot(mm_rdq_take)
      && (mm_rdq_take & ~mm_rdq_granted) == 32'h0000_0000) else $error("take while empty or ungranted");
endmodule

/* testbench/accelerator_socket_interface_tb_top.sv */
// Bench: framework with slots 1 and 6 populated, driven from the host side
`timescale 1ns/1ps
`include "acsi_params.svh"
module accelerator_socket_interface_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hws = 1'b0, hrs = 1'b0, hwv = 1'b0, hwl = 1'b0, hwr, hrv, hidle;
   logic [15:0] ha = 16'h0000;
   logic [31:0] hwd = 32'h0000_0000, hrd, pres, xw = 32'h0000_0000, xpw;
   logic xe = 1'b1, xf = 1'b1, xa = 1'b0, xjr, xjrd, xtk, xpt;
   logic [18:0] xloc, jloc = 19'h0_0000;
   logic [31:0] ust = 32'h0000_5a5a, urw = 32'h0000_0000, pw = 32'h0000_0000;
   logic [8:0] ura = 9'h000;
   logic urwe = 1'b0, jr = 1'b0, jrd = 1'b0, put = 1'b0, take = 1'b0;
   logic [31:0] ctl1, rd6, tw1;
   logic done1, pr1, tr1, tv1;
   int n_fail = 0;
   int checks = 0;
   always #5 clk = ~clk;
   acsi_if sock();
   acsi_framework i_acsi_framework (.clk(clk), .rst(rst), .sock(sock),
      .host_wr_start(hws), .host_addr(ha), .host_wr_valid(hwv), .host_wr_data(hwd),
      .host_wr_last(hwl), .host_wr_ready(hwr), .host_rd_start(hrs), .host_rd_data(hrd),
      .host_rd_valid(hrv), .host_idle(hidle), .slot_presence_word(pres),
      .ext_rdq_empty(xe), .ext_wrq_full(xf), .ext_job_accepted(xa), .ext_rdq_word(xw),
      .ext_job_request(xjr), .ext_job_is_read(xjrd), .ext_location(xloc),
      .ext_rdq_take(xtk), .ext_wrq_put(xpt), .ext_wrq_word(xpw));
   acsi_slot #(.SLOT_INDEX(1)) i_acsi_slot_1 (.sock(sock), .user_ctrl(ctl1),
      .user_status(ust), .user_ram_addr(ura), .user_ram_wdata(urw), .user_ram_we(urwe),
      .user_ram_rdata(), .user_job_req(jr), .user_job_is_read(jrd), .user_job_loc(jloc),
      .user_job_done(done1), .user_put(put), .user_put_word(pw), .user_put_ready(pr1),
      .user_take(take), .user_take_ready(tr1), .user_take_word(tw1), .user_take_valid(tv1));
   acsi_slot #(.SLOT_INDEX(6)) i_acsi_slot_6 (.sock(sock), .user_ctrl(), .user_status(ust),
      .user_ram_addr(ura), .user_ram_wdata(urw), .user_ram_we(urwe), .user_ram_rdata(rd6),
      .user_job_req(1'b0), .user_job_is_read(jrd), .user_job_loc(jloc), .user_job_done(),
      .user_put(1'b0), .user_put_word(pw), .user_put_ready(), .user_take(1'b0),
      .user_take_ready(), .user_take_word(), .user_take_valid());
   for (genvar i = 0; i < `ACSI_SLOTS; i++) begin : g_tie
      if (i != 1 && i != 6) begin : g_off
         assign sock.write_rdy[i] = 1'b0;
         assign sock.data_out[i] = 32'h0000_0000;
         assign sock.strobe_out[i] = 1'b0;
         assign sock.present[i] = 1'b0;
         assign sock.mm_job_request[i] = 1'b0;
         assign sock.mm_job_is_read[i] = 1'b0;
         assign sock.mm_rdq_take[i] = 1'b0;
         assign sock.mm_wrq_put[i] = 1'b0;
         assign sock.mm_ext_location[i] = 19'h0_0000;
         assign sock.mm_wrq_word[i] = 32'h0000_0000;
      end
   end
   acsi_assertions i_acsi_assertions (.clk(sock.clk), .rst(sock.rst),
      .strobe_reg_read(sock.strobe_reg_read), .strobe_reg_write(sock.strobe_reg_write),
      .strobe_ram_read(sock.strobe_ram_read), .strobe_ram_write(sock.strobe_ram_write),
      .write_addr(sock.write_addr), .write_valid(sock.write_valid), .write_rdy(sock.write_rdy),
      .read_addr(sock.read_addr), .strobe_out(sock.strobe_out),
      .mm_rdq_empty(sock.mm_rdq_empty), .mm_wrq_full(sock.mm_wrq_full),
      .mm_job_accepted(sock.mm_job_accepted), .mm_wrq_granted(sock.mm_wrq_granted),
      .mm_rdq_granted(sock.mm_rdq_granted), .mm_job_request(sock.mm_job_request),
      .mm_rdq_take(sock.mm_rdq_take), .mm_wrq_put(sock.mm_wrq_put));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk_b(input string n, input logic e, input logic s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", n, e, s);
      end
   endtask
   task automatic wait_hi(input string n, ref logic s);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (s !== 1'b1 && k < 50);
      chk_b(n, 1'b1, s);
   endtask
   task automatic host_write(input logic [15:0] a, input logic [31:0] w [$]);
      wait_hi("host idle", hidle);
      @(posedge clk);
      hws <= 1'b1;
      ha <= a;
      @(posedge clk);
      hws <= 1'b0;
      foreach (w[i]) begin
         hwv <= 1'b1;
         hwd <= w[i];
         hwl <= (i == w.size() - 1);
         wait_hi("write ready", hwr);
         @(posedge clk);
      end
      hwv <= 1'b0;
      hwl <= 1'b0;
   endtask
   task automatic host_read(input logic [15:0] a, input logic [31:0] e);
      wait_hi("host idle", hidle);
      @(posedge clk);
      hrs <= 1'b1;
      ha <= a;
      @(posedge clk);
      hrs <= 1'b0;
      wait_hi("read valid", hrv);
      chk_w("read data", e, hrd);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_presence;
      host_read(16'h0000, 32'h0000_0042);
      chk_w("presence word", 32'h0000_0042, pres);
      host_write(16'h4400, '{32'hdead_0001});
      host_read(16'h0400, 32'h0000_0000);
      host_read(16'h8000, 32'h0000_0000);
   endtask
   task automatic t_regs;
      host_write(16'h4200, '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003});
      chk_w("control word", 32'h1111_0001, ctl1);
      host_read(16'h0201, 32'h2222_0002);
      host_read(16'h0202, 32'h3333_0003);
      host_read(16'h0200, 32'h0000_5a5a);
      host_write(16'h4c01, '{32'h4444_0004});
      host_read(16'h0c01, 32'h4444_0004);
      host_read(16'h0201, 32'h2222_0002);
   endtask
   task automatic t_ram;
      host_write(16'hcdff, '{32'h5555_0005});
      host_read(16'h8dff, 32'h5555_0005);
      host_read(16'h0c00, 32'h0000_5a5a);
      @(posedge clk);
      ura <= 9'h1ff;
      repeat (2) @(posedge clk);
      chk_w("user ram read", 32'h5555_0005, rd6);
      urwe <= 1'b1;
      ura <= 9'h010;
      urw <= 32'h1357_9bdf;
      @(posedge clk);
      urwe <= 1'b0;
      host_read(16'h8c10, 32'h1357_9bdf);
   endtask
   task automatic t_mem;
      for (int t = 1; t >= 0; t--) begin
         @(posedge clk);
         jloc <= 19'h5_a3c1 ^ 19'(t);
         jrd <= t[0];
         jr <= 1'b1;
         wait_hi("job request", xjr);
         chk_b("job type", t[0], xjrd);
         chk_w("job location", {13'h0000, 19'h5_a3c1 ^ 19'(t)}, {13'h0000, xloc});
         @(posedge clk);
         xa <= 1'b1;
         jr <= 1'b0;
         @(posedge clk);
         xa <= 1'b0;
         @(negedge clk);
         chk_b("job done", 1'b1, done1);
         chk_b("job request low", 1'b0, xjr);
      end
      @(posedge clk);
      xe <= 1'b0;
      xw <= 32'hc0de_0001;
      @(negedge clk);
      chk_b("take ready", 1'b1, tr1);
      @(posedge clk);
      take <= 1'b1;
      @(negedge clk);
      chk_b("queue take", 1'b1, xtk);
      @(posedge clk);
      take <= 1'b0;
      @(negedge clk);
      chk_b("take valid", 1'b1, tv1);
      chk_w("take word", 32'hc0de_0001, tw1);
      @(posedge clk);
      xf <= 1'b0;
      put <= 1'b1;
      pw <= 32'hfeed_0002;
      @(negedge clk);
      chk_b("queue put", 1'b1, xpt);
      chk_w("put word", 32'hfeed_0002, xpw);
      @(posedge clk);
      put <= 1'b0;
      xf <= 1'b1;
      xe <= 1'b1;
      @(negedge clk);
      chk_b("put ready full", 1'b0, pr1);
      chk_b("take ready empty", 1'b0, tr1);
   endtask
   task automatic give_verdict;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_presence();
      t_regs();
      t_ram();
      t_mem();
      give_verdict();
   end
   initial begin
      #100us;
      n_fail++;
      give_verdict();
   end
endmodule
